// ---- design/dark_cal_comp.sv ----
// saturating pixel offset compensation, purely combinational
// the caller registers the result and muxes in raw black samples
`timescale 1ns/1ps
module dark_cal_comp (
   // pixel
   input  wire logic [9:0] pix,
   // correction settings
   input  wire logic       auto_en,
   input  wire logic [9:0] auto_off,
   input  wire logic [8:0] man_mag,
   input  wire logic       man_sub,
   // result
   output logic      [9:0] res
);
   // clip at zero and full scale so a dark pixel never wraps to white
   function automatic logic [9:0] sat_apply(input logic [9:0] a,
                                            input logic [9:0] b,
                                            input logic       sub);
      logic [10:0] s;
      logic [9:0]  r;
      s = sub ? ({1'b0, a} - {1'b0, b}) : ({1'b0, a} + {1'b0, b});
      if (s[10])
         r = sub ? '0 : dark_cal_pkg::PIX_MAX;
      else
         r = s[9:0];
      return r;
   endfunction

   // auto mode ignores the sign bit, manual offset is shared by all
   assign res = auto_en ? sat_apply(pix, auto_off, 1'b1)
                : sat_apply(pix, {1'b0, man_mag}, man_sub);
endmodule // dark_cal_comp

// ---- design/dark_cal_regs.sv ----
// APB register file: sample exponent, offset control, dark rows, flags
// zero wait states; pready follows clk_en so a frozen block stalls the bus
`timescale 1ns/1ps
module dark_cal_regs (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        reset,
   input  wire logic        clk_en,
   // apb
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // events and settings
   input  wire logic [15:0] err_set,
   output logic      [2:0]  samp_exp,
   output logic             auto_en,
   output logic      [8:0]  off_mag,
   output logic             off_sub,
   output logic      [7:0]  dark_rows,
   output logic             gate_first
);
   logic [15:0] err;
   logic [15:0] next_err;
   logic [2:0]  next_samp_exp;
   logic        next_auto_en;
   logic [8:0]  next_off_mag;
   logic        next_off_sub;
   logic [7:0]  next_dark_rows;
   logic        next_gate_first;
   logic [31:0] next_prdata;
   logic [9:0]  idx;
   logic        wr;

   function automatic logic mapped(input logic [9:0] i);
      return i == dark_cal_pkg::IDX_SAMPLE_CFG ||
             i == dark_cal_pkg::IDX_OFFSET_CTRL ||
             i == dark_cal_pkg::IDX_SHORTAGE ||
             i == dark_cal_pkg::IDX_DARK_ROWS;
   endfunction

   assign idx     = paddr[11:2];
   assign pready  = clk_en;
   assign pslverr = psel & penable & ~mapped(idx);
   assign wr      = psel & penable & pwrite & mapped(idx);

   always_comb begin
      next_samp_exp   = samp_exp;
      next_auto_en    = auto_en;
      next_off_mag    = off_mag;
      next_off_sub    = off_sub;
      next_dark_rows  = dark_rows;
      next_gate_first = gate_first;
      next_err        = err;
      next_prdata     = prdata;
      if (wr && idx == dark_cal_pkg::IDX_SAMPLE_CFG)
         next_samp_exp = pwdata[dark_cal_pkg::SAMP_EXP_LSB +: 3];
      if (wr && idx == dark_cal_pkg::IDX_OFFSET_CTRL) begin
         next_auto_en = pwdata[dark_cal_pkg::AUTO_BIT];
         next_off_mag = pwdata[dark_cal_pkg::OFF_LSB +: 9];
         next_off_sub = pwdata[dark_cal_pkg::SIGN_BIT];
      end
      if (wr && idx == dark_cal_pkg::IDX_DARK_ROWS) begin
         next_dark_rows  = pwdata[dark_cal_pkg::ROWS_LSB +: 8];
         next_gate_first = pwdata[dark_cal_pkg::GATE_BIT];
      end
      // write one to clear; a shortage in the same cycle survives
      if (wr && idx == dark_cal_pkg::IDX_SHORTAGE)
         next_err = err & ~pwdata[15:0];
      next_err = next_err | err_set;
      // read data is prepared in the setup cycle, valid in the access
      if (psel && !penable) begin
         next_prdata = '0;
         unique case (idx)
            dark_cal_pkg::IDX_SAMPLE_CFG:
               next_prdata[dark_cal_pkg::SAMP_EXP_LSB +: 3] = samp_exp;
            dark_cal_pkg::IDX_OFFSET_CTRL: begin
               next_prdata[dark_cal_pkg::AUTO_BIT]    = auto_en;
               next_prdata[dark_cal_pkg::OFF_LSB +: 9] = off_mag;
               next_prdata[dark_cal_pkg::SIGN_BIT]    = off_sub;
            end
            dark_cal_pkg::IDX_SHORTAGE:
               next_prdata[15:0] = err;
            dark_cal_pkg::IDX_DARK_ROWS: begin
               next_prdata[dark_cal_pkg::ROWS_LSB +: 8] = dark_rows;
               next_prdata[dark_cal_pkg::GATE_BIT]     = gate_first;
            end
            default: next_prdata = '0;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         samp_exp   <= dark_cal_pkg::RST_SAMP_EXP;
         auto_en    <= dark_cal_pkg::RST_AUTO;
         off_mag    <= dark_cal_pkg::RST_OFF;
         off_sub    <= dark_cal_pkg::RST_SIGN;
         dark_rows  <= dark_cal_pkg::RST_ROWS;
         gate_first <= dark_cal_pkg::RST_GATE;
         err        <= '0;
         prdata     <= '0;
      end else if (clk_en) begin
         samp_exp   <= next_samp_exp;
         auto_en    <= next_auto_en;
         off_mag    <= next_off_mag;
         off_sub    <= next_off_sub;
         dark_rows  <= next_dark_rows;
         gate_first <= next_gate_first;
         err        <= next_err;
         prdata     <= next_prdata;
      end
   end
endmodule // dark_cal_regs

// ---- design/dark_level_calibration.sv ----
// dark row sequencer, per-column black calibration and pixel correction
// assumes one pixel per pix_valid cycle, frame_start a one-cycle pulse
`timescale 1ns/1ps
module dark_level_calibration (
   // clock, reset, enable
   input  wire logic        sys_clk,
   input  wire logic        reset,
   input  wire logic        clk_en,
   // apb
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // frame timing
   input  wire logic        frame_start,
   input  wire logic        global_shutter,
   input  wire logic [12:0] window_len,
   // pixels from the converters
   input  wire logic        pix_valid,
   input  wire logic [9:0]  pix_data,
   // array control and pixel output
   output logic             black_row,
   output logic             out_valid,
   output logic      [9:0]  out_data,
   output logic             out_black
);
   localparam int NC = dark_cal_pkg::KERNEL_COLS;
   localparam int CP = dark_cal_pkg::COLS_PER_PATH;

   // settings
   logic [2:0]  samp_exp;
   logic        auto_en;
   logic [8:0]  off_mag;
   logic        off_sub;
   logic [7:0]  dark_rows;
   logic        gate_first;
   logic [15:0] err_set;

   // sequencer
   dark_cal_pkg::seq_state_t state;
   dark_cal_pkg::seq_state_t next_state;
   logic [7:0]  row;
   logic [7:0]  next_row;
   logic [12:0] col;
   logic [12:0] next_col;
   logic [7:0]  rows_lat;
   logic [7:0]  next_rows_lat;
   logic        gate_lat;
   logic        next_gate_lat;
   logic        cal_end;
   logic        next_cal_end;
   logic [12:0] row_len;
   logic        last_col;
   logic        last_row;
   logic        gated_row;
   logic [5:0]  colk;

   // calibration store
   logic [16:0] acc [NC];
   logic [16:0] next_acc [NC];
   logic [7:0]  cnt [NC];
   logic [7:0]  next_cnt [NC];
   logic [9:0]  off [NC];
   logic [9:0]  next_off [NC];
   logic [NC-1:0] short_col;
   logic [7:0]  need;
   logic        run;
   logic        sample_ok;

   // output
   logic [9:0]  comp;
   logic        next_out_valid;
   logic [9:0]  next_out_data;
   logic        next_out_black;

   dark_cal_regs u_regs (
      .sys_clk    (sys_clk),
      .reset      (reset),
      .clk_en     (clk_en),
      .psel       (psel),
      .penable    (penable),
      .pwrite     (pwrite),
      .paddr      (paddr),
      .pwdata     (pwdata),
      .prdata     (prdata),
      .pready     (pready),
      .pslverr    (pslverr),
      .err_set    (err_set),
      .samp_exp   (samp_exp),
      .auto_en    (auto_en),
      .off_mag    (off_mag),
      .off_sub    (off_sub),
      .dark_rows  (dark_rows),
      .gate_first (gate_first)
   );

   // row length follows the shutter mode
   assign row_len   = global_shutter ? dark_cal_pkg::GS_ROW_PIXELS
                                     : window_len;
   assign last_col  = (col == row_len - 13'h0001);
   // a zero row count is outside the allowed range and wraps to 256
   assign last_row  = (row == rows_lat - 8'h01);
   assign gated_row = gate_lat && row == '0;
   assign colk      = col[5:0];
   assign black_row = (state == dark_cal_pkg::ST_BLACK);

   always_comb begin
      next_state    = state;
      next_row      = row;
      next_col      = col;
      next_rows_lat = rows_lat;
      next_gate_lat = gate_lat;
      next_cal_end  = 1'b0;
      if (frame_start) begin
         // row settings are taken at the frame boundary only
         next_state    = dark_cal_pkg::ST_BLACK;
         next_row      = '0;
         next_col      = '0;
         next_rows_lat = dark_rows;
         next_gate_lat = gate_first;
      end else begin
         unique case (state)
            dark_cal_pkg::ST_IDLE: ;
            dark_cal_pkg::ST_BLACK:
               if (pix_valid) begin
                  next_col = last_col ? '0 : col + 13'h0001;
                  if (last_col && last_row) begin
                     next_state   = dark_cal_pkg::ST_IMAGE;
                     next_row     = '0;
                     next_cal_end = 1'b1;
                  end else if (last_col) begin
                     next_row = row + 8'h01;
                  end
               end
            dark_cal_pkg::ST_IMAGE:
               if (pix_valid)
                  next_col = last_col ? '0 : col + 13'h0001;
            default: next_state = dark_cal_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state    <= dark_cal_pkg::ST_IDLE;
         row      <= '0;
         col      <= '0;
         rows_lat <= dark_cal_pkg::RST_ROWS;
         gate_lat <= dark_cal_pkg::RST_GATE;
         cal_end  <= 1'b0;
      end else if (clk_en) begin
         state    <= next_state;
         row      <= next_row;
         col      <= next_col;
         rows_lat <= next_rows_lat;
         gate_lat <= next_gate_lat;
         cal_end  <= next_cal_end;
      end
   end

   // calibration: 0x1FF in auto mode freezes the stored offsets
   assign run  = auto_en && off_mag != dark_cal_pkg::FREEZE_CODE;
   assign need = dark_cal_pkg::ONE_SAMPLE << samp_exp;
   assign sample_ok = black_row && pix_valid && !gated_row;

   genvar g;
   generate
      for (g = 0; g < NC; g++) begin : g_short
         assign short_col[g] = cnt[g] < need;
      end
      for (g = 0; g < dark_cal_pkg::NUM_PATHS; g++) begin : g_err
         assign err_set[g] = cal_end && run
                             && |short_col[g*CP +: CP];
      end
   endgenerate

   always_comb begin
      for (int c = 0; c < NC; c++) begin
         next_acc[c] = acc[c];
         next_cnt[c] = cnt[c];
         next_off[c] = off[c];
      end
      // low-pass filter: sum only the first 2^exp samples per column
      if (sample_ok && short_col[colk]) begin
         next_acc[colk] = acc[colk] + 17'(pix_data);
         next_cnt[colk] = cnt[colk] + 8'h01;
      end
      if (cal_end || frame_start) begin
         for (int c = 0; c < NC; c++) begin
            // a starved column keeps its old offset rather than a bad one
            if (cal_end && run && !short_col[c])
               next_off[c] = 10'(acc[c] >> samp_exp);
            next_acc[c] = '0;
            next_cnt[c] = '0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         for (int c = 0; c < NC; c++) begin
            acc[c] <= '0;
            cnt[c] <= '0;
            off[c] <= '0;
         end
      end else if (clk_en) begin
         for (int c = 0; c < NC; c++) begin
            acc[c] <= next_acc[c];
            cnt[c] <= next_cnt[c];
            off[c] <= next_off[c];
         end
      end
   end

   dark_cal_comp u_comp (
      .pix      (pix_data),
      .auto_en  (auto_en),
      .auto_off (off[colk]),
      .man_mag  (off_mag),
      .man_sub  (off_sub),
      .res      (comp)
   );

   always_comb begin
      next_out_valid = 1'b0;
      next_out_black = 1'b0;
      next_out_data  = out_data;
      if (pix_valid && state == dark_cal_pkg::ST_BLACK) begin
         next_out_valid = !gated_row;
         next_out_black = 1'b1;
         next_out_data  = pix_data;
      end else if (pix_valid && state == dark_cal_pkg::ST_IMAGE) begin
         next_out_valid = 1'b1;
         next_out_data  = comp;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         out_valid <= 1'b0;
         out_black <= 1'b0;
         out_data  <= '0;
      end else if (clk_en) begin
         out_valid <= next_out_valid;
         out_black <= next_out_black;
         out_data  <= next_out_data;
      end
   end
endmodule // dark_level_calibration

// ---- inc/dark_cal_pkg.sv ----
// constants, register map and types of the dark level calibration block
// assumes a 100 MHz sys_clk and APB with 32-bit data, one word per register
package dark_cal_pkg;
   // register indices; byte address is four times the index
   localparam logic [9:0] IDX_SAMPLE_CFG  = 10'h080;
   localparam logic [9:0] IDX_OFFSET_CTRL = 10'h081;
   localparam logic [9:0] IDX_SHORTAGE    = 10'h088;
   localparam logic [9:0] IDX_DARK_ROWS   = 10'h0C5;
   // field positions
   localparam int SAMP_EXP_LSB = 8;
   localparam int AUTO_BIT     = 0;
   localparam int OFF_LSB      = 1;
   localparam int SIGN_BIT     = 10;
   localparam int ROWS_LSB     = 0;
   localparam int GATE_BIT     = 8;
   // reset values
   localparam logic [2:0] RST_SAMP_EXP = 3'h3;
   localparam logic       RST_AUTO     = 1'b1;
   localparam logic [8:0] RST_OFF      = 9'h000;
   localparam logic       RST_SIGN     = 1'b0;
   localparam logic [7:0] RST_ROWS     = 8'h08;
   localparam logic       RST_GATE     = 1'b1;
   // geometry and codes
   localparam int KERNEL_COLS   = 64;
   localparam int GS_KERNELS    = 80;
   localparam logic [12:0] GS_ROW_PIXELS = 13'(GS_KERNELS * KERNEL_COLS);
   localparam int NUM_PATHS     = 16;
   localparam int COLS_PER_PATH = KERNEL_COLS / NUM_PATHS;
   localparam logic [8:0] FREEZE_CODE = 9'h1FF;
   localparam logic [9:0] PIX_MAX     = 10'h3FF;
   localparam logic [7:0] ONE_SAMPLE  = 8'h01;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_BLACK = 2'b01,
      ST_IMAGE = 2'b10
   } seq_state_t;
endpackage

// ---- sim/dark_level_calibration_asserts.sv ----
// checker for dark_level_calibration: bus answers, marking, raw and manual data
// assumes it is bound to the top module and sees its ports only
`timescale 1ns/1ps
module dark_level_calibration_asserts (
   // clock and reset
   input wire logic        sys_clk,
   input wire logic        reset,
   input wire logic        clk_en,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // frame and pixels
   input wire logic        frame_start,
   input wire logic        global_shutter,
   input wire logic [12:0] window_len,
   input wire logic        pix_valid,
   input wire logic [9:0]  pix_data,
   input wire logic        black_row,
   input wire logic        out_valid,
   input wire logic [9:0]  out_data,
   input wire logic        out_black
);
   logic       auto_on;
   logic [8:0] mag;
   logic       sub;
   logic [9:0] last_pix;
   logic [9:0] man_exp;
   int         sum;
   // shadow of the offset control word, enough to predict manual output
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         auto_on <= 1'b1;
         mag <= 9'h000;
         sub <= 1'b0;
      end else if (psel && penable && pwrite && pready && paddr == 12'h204) begin
         auto_on <= pwdata[0];
         mag <= pwdata[9:1];
         sub <= pwdata[10];
      end
   end
   always_ff @(posedge sys_clk) begin
      if (clk_en && pix_valid) begin
         last_pix <= pix_data;
      end
   end
   always_comb begin
      sum = sub ? int'(last_pix) - int'(mag) : int'(last_pix) + int'(mag);
      man_exp = sum < 0 ? 10'h000 : (sum > 1023 ? 10'h3FF : 10'(sum));
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   a_pready_en: assert property (pready == clk_en)
      else $error("pready does not follow clk_en");
   a_err_access: assert property (pslverr |-> psel && penable)
      else $error("pslverr outside an access phase");
   a_err_unmapped: assert property (psel && penable && paddr == 12'h3FC
      |-> pslverr) else $error("unmapped access not refused");
   a_black_start: assert property (frame_start && clk_en |=> black_row)
      else $error("no black phase after frame start");
   a_out_cause: assert property (out_valid && $past(clk_en) |->
      $past(pix_valid)) else $error("output pixel without input pixel");
   a_black_raw: assert property (out_valid && out_black |->
      out_data == last_pix) else $error("black sample not raw");
   a_black_mark: assert property (out_valid && out_black |->
      $past(black_row)) else $error("black mark outside black phase");
   a_image_plain: assert property (out_valid && $past(clk_en) &&
      !$past(black_row) |-> !out_black) else $error("image pixel marked black");
   a_manual_corr: assert property (out_valid && !out_black && !auto_on
      |-> out_data == man_exp) else $error("manual correction wrong");
endmodule // dark_level_calibration_asserts

bind dark_level_calibration dark_level_calibration_asserts i_asserts (
   .sys_clk, .reset, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .pready, .pslverr, .frame_start, .global_shutter, .window_len,
   .pix_valid, .pix_data, .black_row, .out_valid, .out_data, .out_black);

// ---- sim/dark_level_calibration_tb.sv ----
// self-checking bench for dark_level_calibration: apb, auto, manual frames
// assumes the checker binds itself; all inputs change at rising edges
`timescale 1ns/1ps
module dark_level_calibration_tb;
   logic        sys_clk, reset, clk_en, psel, penable, pwrite, pready;
   logic        pslverr, frame_start, global_shutter, pix_valid, black_row;
   logic        out_valid, out_black, err, m_auto, m_sub, m_gate;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [12:0] window_len;
   logic [9:0]  pix_data, out_data;
   logic [10:0] expq[$];
   logic [8:0]  m_mag;
   logic [2:0]  m_exp;
   logic [7:0]  m_rows;
   logic [15:0] m_flags;
   int          n_fail, n_compared, off[64], sum[64], cnt[64];

   dark_level_calibration i_dark_level_calibration (.sys_clk, .reset,
      .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .frame_start, .global_shutter, .window_len, .pix_valid,
      .pix_data, .black_row, .out_valid, .out_data, .out_black);

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic end_sim();
      $display("mismatches %0d, comparisons %0d", n_fail, n_compared);
      if (n_fail == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         n_fail++;
         end_sim();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] e,
                        input logic ee);
      apb(1'b0, a, 32'h0000_0000);
      cmp(rd, e);
      cmp(32'(err), 32'(ee));
   endtask

   // settings shadow follows every cfg write so expectations match the block
   task automatic cfg(input logic a, input logic [8:0] m, input logic s,
                      input logic [2:0] e, input logic [7:0] r,
                      input logic g);
      m_auto = a;
      m_mag = m;
      m_sub = s;
      m_exp = e;
      m_rows = r;
      m_gate = g;
      apb(1'b1, 12'h200, {21'h0, e, 8'h00});
      apb(1'b1, 12'h204, {21'h0, s, m, a});
      apb(1'b1, 12'h314, {23'h0, g, r});
   endtask

   task automatic pix(input logic [9:0] v, input logic show,
                      input logic blk, input logic [9:0] ev);
      @(posedge sys_clk);
      pix_valid <= 1'b1;
      pix_data <= v;
      if (show) expq.push_back({blk, ev});
   endtask

   function automatic logic [9:0] sat(input int v);
      return v < 0 ? 10'h000 : (v > 1023 ? 10'h3FF : 10'(v));
   endfunction

   task automatic frame(input int len, input int nimg);
      logic [9:0] v;
      logic       keep;
      int         c;
      @(posedge sys_clk);
      frame_start <= 1'b1;
      @(posedge sys_clk);
      frame_start <= 1'b0;
      for (int i = 0; i < 64; i++) begin
         sum[i] = 0;
         cnt[i] = 0;
      end
      for (int r = 0; r < m_rows; r++) begin
         for (int i = 0; i < len; i++) begin
            v = 10'($urandom_range(40, 200));
            c = i % 64;
            keep = !(m_gate && r == 0);
            if (keep && cnt[c] < (1 << m_exp)) begin
               sum[c] += v;
               cnt[c]++;
            end
            pix(v, keep, 1'b1, v);
         end
      end
      // idle gap lets the new offsets settle before the image starts
      @(posedge sys_clk);
      pix_valid <= 1'b0;
      @(posedge sys_clk);
      if (m_auto && m_mag != 9'h1FF)
         for (int i = 0; i < 64; i++)
            if (cnt[i] >= (1 << m_exp)) off[i] = sum[i] >> m_exp;
            else m_flags[i / 4] = 1'b1;
      for (int k = 0; k < nimg; k++) begin
         v = 10'($urandom);
         if (m_auto) c = int'(v) - off[k % 64];
         else c = m_sub ? int'(v) - int'(m_mag) : int'(v) + int'(m_mag);
         pix(v, 1'b1, 1'b0, sat(c));
      end
      @(posedge sys_clk);
      pix_valid <= 1'b0;
   endtask

   always @(posedge sys_clk) begin
      if (out_valid === 1'b1) begin
         if (expq.size() == 0) begin
            n_fail++;
            $display("Error %0t: pixel out of turn", $time);
         end else
            cmp(32'({out_black, out_data}), 32'(expq.pop_front()));
      end
   end

   initial begin
      reset = 1'b1;
      clk_en = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      frame_start = 1'b0;
      global_shutter = 1'b0;
      window_len = 13'h0040;
      pix_valid = 1'b0;
      pix_data = 10'h000;
      m_flags = 16'h0000;
      void'($urandom(38));
      repeat (16) @(posedge sys_clk);
      reset <= 1'b0;
      rdchk(12'h200, 32'h0000_0300, 1'b0);
      rdchk(12'h204, 32'h0000_0001, 1'b0);
      rdchk(12'h220, 32'h0000_0000, 1'b0);
      rdchk(12'h314, 32'h0000_0108, 1'b0);
      rdchk(12'h3FC, 32'h0000_0000, 1'b1);
      apb(1'b1, 12'h314, 32'hFFFF_FFFF);
      rdchk(12'h314, 32'h0000_01FF, 1'b0);
      fork
         rdchk(12'h314, 32'h0000_01FF, 1'b0);
         begin
            repeat (2) @(posedge sys_clk);
            clk_en <= 1'b0;
            repeat (3) @(posedge sys_clk);
            clk_en <= 1'b1;
         end
      join
      cfg(1'b1, 9'h000, 1'b1, 3'h1, 8'h03, 1'b0);
      frame(64, 128);
      cfg(1'b1, 9'h000, 1'b0, 3'h1, 8'h03, 1'b1);
      frame(64, 128);
      cfg(1'b1, 9'h1FF, 1'b0, 3'h1, 8'h03, 1'b1);
      frame(64, 128);
      cfg(1'b1, 9'h005, 1'b0, 3'h1, 8'h03, 1'b1);
      frame(64, 128);
      // one usable row cannot give eight samples, so every path is short
      cfg(1'b1, 9'h000, 1'b0, 3'h3, 8'h02, 1'b1);
      frame(64, 64);
      rdchk(12'h220, {16'h0000, m_flags}, 1'b0);
      apb(1'b1, 12'h220, {16'h0000, m_flags});
      m_flags = 16'h0000;
      rdchk(12'h220, 32'h0000_0000, 1'b0);
      global_shutter <= 1'b1;
      cfg(1'b1, 9'h000, 1'b0, 3'h0, 8'h01, 1'b0);
      frame(5120, 64);
      global_shutter <= 1'b0;
      window_len <= 13'h0080;
      cfg(1'b1, 9'h000, 1'b0, 3'h0, 8'h02, 1'b0);
      frame(128, 64);
      window_len <= 13'h0040;
      for (int s = 0; s < 3; s++) begin
         cfg(1'b0, s == 2 ? 9'h1FF : 9'($urandom_range(1, 300)), s == 1,
             3'h1, 8'h02, 1'b0);
         frame(64, 128);
      end
      for (int n = 0; n < 20 && expq.size() > 0; n++) @(posedge sys_clk);
      cmp(32'(expq.size()), 32'h0000_0000);
      end_sim();
   end
endmodule // dark_level_calibration_tb
